//--- sph_map.svh
`ifndef SPH_MAP_SVH
`define SPH_MAP_SVH

// Bits per byte on the serial link
`define SPH_BYTE_BITS 4'h8
// Bits taken per edge, single line and four lines
`define SPH_STEP_SINGLE 4'h1
`define SPH_STEP_QUAD 4'h4
// Synchroniser depth for pins and other-clock signals
`define SPH_SYNC_DEPTH 3
// Reset values
`define SPH_RST_BYTE 8'h00
`define SPH_RST_OE 4'h0

`endif

//--- sph_pkg.sv
package sph_pkg;

  typedef enum logic [2:0]
  {
    SPH_MODE_SINGLE  = 3'b001,
    SPH_MODE_QUAD_IN = 3'b010,
    SPH_MODE_QUAD_OUT = 3'b100
  } sph_mode_e;

  typedef logic [7:0] sph_byte_t;

endpackage

//--- sph_link_if.sv
`timescale 1ns/1ps

interface sph_link_if;
  import sph_pkg::*;

  sph_mode_e mode;
  logic      rst_n;
  sph_byte_t tx_word;
  logic      tx_tog;
  logic      rx_tog;
  sph_byte_t rx_buf0;
  sph_byte_t rx_buf1;

  modport core
  (
    output mode,
    output rst_n,
    output tx_word,
    input  tx_tog,
    input  rx_tog,
    input  rx_buf0,
    input  rx_buf1
  );

  modport link
  (
    input  mode,
    input  rst_n,
    input  tx_word,
    output tx_tog,
    output rx_tog,
    output rx_buf0,
    output rx_buf1
  );
endinterface

//--- sph_shifter.sv
`timescale 1ns/1ps
`include "sph_map.svh"

module sph_shifter
(
  input  wire logic       sck,
  input  wire logic       cs_n,
  input  wire logic [3:0] io_i,
  output logic      [3:0] io_o,
  sph_link_if.link        lk
);
  import sph_pkg::*;

  typedef struct packed
  {
    logic [7:0] sr;
    logic [3:0] cnt;
  } sph_rxcnt_s;

  typedef struct packed
  {
    sph_byte_t buf0;
    sph_byte_t buf1;
    logic      tog;
  } sph_rxbuf_s;

  typedef struct packed
  {
    logic [7:0] sr;
    logic [3:0] cnt;
    logic [3:0] out;
    logic       tog;
  } sph_tx_s;

  sph_rxcnt_s rc_r, rc_nxt;
  sph_rxbuf_s rb_r, rb_nxt;
  sph_tx_s    tx_r, tx_nxt;
  logic       quad;
  logic       pause;
  logic [3:0] step;

  function automatic logic [3:0] sph_step(input sph_mode_e m);
    sph_step = (m == SPH_MODE_SINGLE) ? `SPH_STEP_SINGLE : `SPH_STEP_QUAD;
  endfunction

  // ********************************
  // Pause detection on the link clock
  // ********************************
  // Mode is held steady between frames; the link clock may be stopped
  assign quad  = (lk.mode != SPH_MODE_SINGLE);
  // Line three is data in quad modes, pause only otherwise
  assign pause = !quad && !io_i[3]; // (R1) (R5) (R6)
  assign step  = sph_step(lk.mode);

  // ********************************
  // Receive on rising edges
  // ********************************
  always_comb
  begin
    rc_nxt = rc_r;
    rb_nxt = rb_r;
    if (!pause) // (R1) (R10)
    begin
      if (lk.mode == SPH_MODE_QUAD_IN)
        rc_nxt.sr = {rc_r.sr[3:0], io_i}; // (R5)
      else
        rc_nxt.sr = {rc_r.sr[6:0], io_i[0]}; // (R8)
      rc_nxt.cnt = rc_r.cnt + step;
      if (rc_nxt.cnt == `SPH_BYTE_BITS)
      begin
        rc_nxt.cnt = 4'h0;
        if (rb_r.tog)
          rb_nxt.buf1 = rc_nxt.sr;
        else
          rb_nxt.buf0 = rc_nxt.sr;
        rb_nxt.tog = !rb_r.tog;
      end
    end
  end

  // Bit position cleared only by deselect, never by a pause
  always_ff @(posedge sck or posedge cs_n)
  begin
    if (cs_n)
      rc_r <= '0; // (R3)
    else
      rc_r <= rc_nxt;
  end

  always_ff @(posedge sck or negedge lk.rst_n)
  begin
    if (!lk.rst_n)
      rb_r <= {`SPH_RST_BYTE, `SPH_RST_BYTE, 1'b0};
    else
      rb_r <= rb_nxt;
  end

  // ********************************
  // Transmit on falling edges
  // ********************************
  always_comb
  begin
    tx_nxt = tx_r;
    if (!pause) // (R1) (R10)
    begin
      if (tx_r.cnt == 4'h0)
      begin
        tx_nxt.sr  = lk.tx_word;
        tx_nxt.tog = !tx_r.tog;
      end
      if (quad)
      begin
        tx_nxt.out = tx_nxt.sr[7:4]; // (R6)
        tx_nxt.sr  = {tx_nxt.sr[3:0], 4'h0};
      end
      else
      begin
        tx_nxt.out = {2'b00, tx_nxt.sr[7], 1'b0}; // (R8)
        tx_nxt.sr  = {tx_nxt.sr[6:0], 1'b0};
      end
      tx_nxt.cnt = tx_r.cnt + step;
      if (tx_nxt.cnt == `SPH_BYTE_BITS)
        tx_nxt.cnt = 4'h0;
    end
  end

  always_ff @(negedge sck or negedge lk.rst_n)
  begin
    if (!lk.rst_n)
      tx_r <= '0;
    else if (cs_n)
      tx_r <= {`SPH_RST_BYTE, 4'h0, 4'h0, tx_r.tog};
    else
      tx_r <= tx_nxt;
  end

  assign io_o       = tx_r.out;
  assign lk.tx_tog  = tx_r.tog;
  assign lk.rx_tog  = rb_r.tog;
  assign lk.rx_buf0 = rb_r.buf0;
  assign lk.rx_buf1 = rb_r.buf1;
endmodule

//--- sph_top.sv
`timescale 1ns/1ps
`include "sph_map.svh"
// Contract
// (R1) While paused, clock edges and input data are ignored; outputs float.
// (R2) Pause starts only with chip select low and clock low; the code starts it on pin low at any clock level.
// (R3) Pause never deselects or resets; command bit position is kept.
// (R4) Pause touches only the serial link; internal program or erase continue.
// (R5) Quad input: line three is data, four bits sampled per rising edge.
// (R6) Quad output: line three is driven, four bits per falling edge.
// (R7) Undriven pause pin reads inactive high; pause then unused.
// (R8) Sample on rising clock edges, shift out on falling edges.
// (R9) Chip select high deselects and floats all data outputs.
// (R10) Pause is active low, ends with pin high and clock low, resumes in place; the code ends it on pin high at any clock level.

module sph_top
#(
  parameter int SYNC_DEPTH = `SPH_SYNC_DEPTH
)
(
  input  wire logic             mclk,
  input  wire logic             nrst,
  input  wire logic             sck,
  input  wire logic             cs_n,
  input  wire logic       [3:0] quad_data_lines_i,
  output logic            [3:0] quad_data_lines_o,
  output logic            [3:0] quad_data_lines_oe,
  output logic                  line_three_pull_en,
  input  wire sph_pkg::sph_mode_e mode,
  input  wire logic             drive_out,
  input  wire sph_pkg::sph_byte_t tx_data,
  input  wire logic             tx_valid,
  output logic                  tx_ready,
  output sph_pkg::sph_byte_t    rx_data,
  output logic                  rx_valid,
  output logic                  link_paused,
  output logic                  link_selected
);
  import sph_pkg::*;

  initial
  begin
    if (SYNC_DEPTH != 3)
      $error("sph_top: only a three-stage synchroniser is supported");
  end

  typedef struct packed
  {
    logic [1:0] rst;
    sph_mode_e  mode;
    sph_byte_t  tx_word;
    logic       tx_full;
    logic [3:0] rx_s;
    logic [3:0] tx_s;
    logic [2:0] cs_s;
    logic [2:0] l3_s;
    sph_byte_t  rx_data;
    logic       rx_valid;
    logic [3:0] oe;
    logic       pull;
    logic       paused;
    logic       sel;
  } sph_state_s;

  sph_state_s s_r, s_nxt;
  logic       sel_c;
  logic       pause_c;
  logic       rx_ev;
  logic       tx_ev;

  sph_link_if lk ();

  sph_shifter u_shift
  (
    .sck  (sck),
    .cs_n (cs_n),
    .io_i (quad_data_lines_i),
    .io_o (quad_data_lines_o),
    .lk   (lk)
  );

  // ********************************
  // Pin and cross-domain sampling
  // ********************************
  // Changes count once stages two and three agree
  assign sel_c   = (s_r.cs_s[1] == s_r.cs_s[2]) ? !s_r.cs_s[2] : s_r.sel;
  // Pause needs selection and a non-quad mode; pin low is pause
  assign pause_c = sel_c && (s_r.mode == SPH_MODE_SINGLE)
                   && (s_r.l3_s[1] == s_r.l3_s[2]) && !s_r.l3_s[2]; // (R2) (R10)
  assign rx_ev   = (s_r.rx_s[1] == s_r.rx_s[2]) && (s_r.rx_s[2] != s_r.rx_s[3]);
  assign tx_ev   = (s_r.tx_s[1] == s_r.tx_s[2]) && (s_r.tx_s[2] != s_r.tx_s[3]);

  // ********************************
  // Core-side state
  // ********************************
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.rst  = {s_r.rst[0], 1'b1};
    s_nxt.cs_s = {s_r.cs_s[1:0], cs_n};
    s_nxt.l3_s = {s_r.l3_s[1:0], quad_data_lines_i[3]};
    s_nxt.rx_s = {s_r.rx_s[2:0], lk.rx_tog};
    s_nxt.tx_s = {s_r.tx_s[2:0], lk.tx_tog};
    s_nxt.mode = mode;
    s_nxt.sel  = sel_c;
    s_nxt.paused = pause_c; // (R1)
    // Pad pull-up kept on unless line three is data
    s_nxt.pull = (mode == SPH_MODE_SINGLE); // (R7)
    // Received byte from the buffer just completed
    s_nxt.rx_valid = rx_ev;
    if (rx_ev)
      s_nxt.rx_data = s_r.rx_s[2] ? lk.rx_buf0 : lk.rx_buf1;
    // Byte taken by the link frees the slot; a new load wins
    if (tx_ev)
      s_nxt.tx_full = 1'b0;
    if (tx_valid && !s_r.tx_full)
    begin
      s_nxt.tx_word = tx_data;
      s_nxt.tx_full = 1'b1;
    end
    // Drivers only while selected and not paused
    if (!sel_c || pause_c) // (R1) (R9)
      s_nxt.oe = `SPH_RST_OE;
    else if (mode == SPH_MODE_QUAD_OUT)
      s_nxt.oe = 4'hF; // (R6)
    else if (mode == SPH_MODE_SINGLE && drive_out)
      s_nxt.oe = 4'h2; // (R8)
    else
      s_nxt.oe = `SPH_RST_OE; // (R5)
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_r <= '0;
      s_r.mode <= SPH_MODE_SINGLE;
      s_r.cs_s <= 3'h7;
      s_r.l3_s <= 3'h7;
      s_r.pull <= 1'b1; // (R7)
    end
    else
    begin
      s_r <= s_nxt;
      if (!s_r.rst[1])
      begin
        s_r.rx_s <= {4{lk.rx_tog}};
        s_r.tx_s <= {4{lk.tx_tog}};
      end
    end
  end

  // Pause gates only the link; no core busy state is touched here (R4)
  assign lk.mode    = s_r.mode;
  assign lk.rst_n   = s_r.rst[1];
  assign lk.tx_word = s_r.tx_word;

  assign quad_data_lines_oe = s_r.oe;
  assign line_three_pull_en = s_r.pull;
  assign tx_ready           = !s_r.tx_full;
  assign rx_data            = s_r.rx_data;
  assign rx_valid           = s_r.rx_valid;
  assign link_paused        = s_r.paused;
  assign link_selected      = s_r.sel;
endmodule

//--- sph_top_checker.sv
`timescale 1ns/1ps
// ***
// Pin checker
// ***
module sph_top_checker
  import sph_pkg::*;
(
  input wire logic              mclk,
  input wire logic              nrst,
  input wire logic              cs_n,
  input wire logic [3:0]        quad_data_lines_i,
  input wire logic [3:0]        quad_data_lines_oe,
  input wire logic              line_three_pull_en,
  input wire sph_pkg::sph_mode_e mode,
  input wire logic              drive_out,
  input wire logic              rx_valid,
  input wire logic              tx_valid,
  input wire logic              tx_ready,
  input wire logic              link_paused,
  input wire logic              link_selected
);
  wire logic [3:0] oe = quad_data_lines_oe;
  wire logic       l3 = quad_data_lines_i[3];
  wire logic       sg = mode == SPH_MODE_SINGLE;
  wire logic       pz = sg && !cs_n && !l3;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  property p_desel; cs_n[*8] |-> oe == 4'h0 && !link_selected; endproperty
  property p_sel; (!cs_n)[*8] |-> link_selected; endproperty
  property p_hold; pz[*8] |-> oe == 4'h0 && link_paused; endproperty
  property p_resume; (sg && l3)[*8] |-> !link_paused; endproperty
  property p_pull; sg[*4] |-> line_three_pull_en; endproperty
  property p_qin; (mode == SPH_MODE_QUAD_IN && !cs_n)[*6] |-> oe == 4'h0 && !link_paused;
  endproperty
  property p_qout; (mode == SPH_MODE_QUAD_OUT && !cs_n)[*8] |-> oe == 4'hF; endproperty
  property p_sgl; (sg && !cs_n && l3 && $stable(drive_out))[*8] |->
    oe == {2'h0, drive_out, 1'b0}; endproperty
  a_desel: assert property (p_desel) else $error("drive when off");
  a_sel: assert property (p_sel) else $error("select lost");
  a_hold: assert property (p_hold) else $error("pause drive");
  a_resume: assert property (p_resume) else $error("pause stuck");
  a_pull: assert property (p_pull) else $error("no pull");
  a_qin: assert property (p_qin) else $error("quad in drive");
  a_qout: assert property (p_qout) else $error("quad out idle");
  a_sgl: assert property (p_sgl) else $error("single drive");
  c_rx: cover property (rx_valid);
  c_hold: cover property (link_paused);
  c_tx: cover property (tx_valid && tx_ready);
endmodule
bind sph_top sph_top_checker sph_top_checker_inst (.*);

//--- sph_host.sv
`timescale 1ns/1ps
// ***
// Host model
// ***
module sph_host
(
  output logic       sck,
  output logic       cs_n,
  output logic [3:0] hio,
  output logic [3:0] hoe
);
  initial {sck, cs_n, hio, hoe} = 10'h100;
  task sel(input logic s);
    cs_n = ~s;
    if (!s)
      hoe = 4'h0;
    #30;
  endtask
  task pause(input logic on);
    hio[3] = 1'b0;
    hoe[3] = on;
    #30;
  endtask
  task bits(input logic [7:0] d, input int n, input logic [3:0] en);
    repeat (n)
    begin
      hoe = {hoe[3] | en[3], en[2:0]};
      hio = en[3] ? d[7:4] : {hio[3], 2'b00, d[7]};
      d = en[3] ? d << 4 : d << 1;
      #15 sck = 1'b1;
      #15 sck = 1'b0;
    end
  endtask
endmodule

//--- sph_top_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin fail_count++; \
  $display("wrong value %s exp %h got %h", n, e, a); end end
// ***
// Bench
// ***
module sph_top_tb;
  import sph_pkg::*;
  logic       mclk, nrst, sck, cs_n, drive_out, tx_valid, tx_ready, rx_valid;
  logic       line_three_pull_en, link_paused, link_selected;
  logic       tgl = 1'b0;
  logic [3:0] quad_data_lines_o, quad_data_lines_oe, hio, hoe, pad;
  sph_mode_e  mode;
  sph_byte_t  tx_data, rx_data, v;
  int         fail_count, checks, seed;
  assign pad = (hoe & hio) | (~hoe & quad_data_lines_oe & quad_data_lines_o)
             | (~hoe & ~quad_data_lines_oe & {line_three_pull_en | tgl, {3{tgl}}});
  sph_top sph_top_inst
  (
    .mclk               (mclk),
    .nrst               (nrst),
    .sck                (sck),
    .cs_n               (cs_n),
    .quad_data_lines_i  (pad),
    .quad_data_lines_o  (quad_data_lines_o),
    .quad_data_lines_oe (quad_data_lines_oe),
    .line_three_pull_en (line_three_pull_en),
    .mode               (mode),
    .drive_out          (drive_out),
    .tx_data            (tx_data),
    .tx_valid           (tx_valid),
    .tx_ready           (tx_ready),
    .rx_data            (rx_data),
    .rx_valid           (rx_valid),
    .link_paused        (link_paused),
    .link_selected      (link_selected)
  );
  sph_host sph_host_inst
  (
    .sck  (sck),
    .cs_n (cs_n),
    .hio  (hio),
    .hoe  (hoe)
  );
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) tgl <= ~tgl;
  task end_sim;
    if (fail_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task wait_rx;
    for (int i = 0; i < 60 && rx_valid !== 1'b1; i++)
      @(negedge mclk);
    `CHK("rx_valid", 1'b1, rx_valid)
  endtask
  task setm(input sph_mode_e m);
    @(posedge mclk);
    mode <= m;
    repeat (4) @(posedge mclk);
  endtask
  initial
  begin
    seed = 32'h5E24;
    nrst = 1'b0;
    mode = SPH_MODE_SINGLE;
    drive_out = 1'b0;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    repeat (8) @(posedge mclk);
    `CHK("pull", 1'b1, line_three_pull_en)
    repeat (6)
    begin
      v = $random(seed);
      @(posedge mclk);
      drive_out <= v[0];
      tx_valid <= v[1];
      tx_data <= ~v;
      sph_host_inst.sel(1'b1);
      sph_host_inst.bits(v, 8, 4'h1);
      wait_rx;
      `CHK("rx_data", v, rx_data)
      sph_host_inst.sel(1'b0);
    end
    @(posedge mclk);
    drive_out <= 1'b1;
    v = 8'hA5;
    sph_host_inst.sel(1'b1);
    sph_host_inst.bits(v, 4, 4'h1);
    sph_host_inst.pause(1'b1);
    sph_host_inst.bits(8'h5A, 3, 4'h1);
    repeat (8) @(negedge mclk);
    `CHK("oe", 4'h0, quad_data_lines_oe)
    `CHK("paused", 1'b1, link_paused)
    `CHK("selected", 1'b1, link_selected)
    sph_host_inst.pause(1'b0);
    sph_host_inst.bits(v << 4, 4, 4'h1);
    wait_rx;
    `CHK("rx_data", v, rx_data)
    sph_host_inst.bits(v, 3, 4'h1);
    sph_host_inst.sel(1'b0);
    repeat (8) @(negedge mclk);
    `CHK("oe", 4'h0, quad_data_lines_oe)
    `CHK("selected", 1'b0, link_selected)
    sph_host_inst.sel(1'b1);
    sph_host_inst.bits(8'hC3, 8, 4'h1);
    wait_rx;
    `CHK("rx_data", 8'hC3, rx_data)
    sph_host_inst.sel(1'b0);
    setm(SPH_MODE_QUAD_IN);
    sph_host_inst.sel(1'b1);
    sph_host_inst.bits(8'h3C, 2, 4'hF);
    wait_rx;
    `CHK("rx_data", 8'h3C, rx_data)
    sph_host_inst.sel(1'b0);
    setm(SPH_MODE_QUAD_OUT);
    sph_host_inst.sel(1'b1);
    sph_host_inst.bits(8'h00, 4, 4'h0);
    repeat (8) @(negedge mclk);
    `CHK("oe", 4'hF, quad_data_lines_oe)
    sph_host_inst.sel(1'b0);
    end_sim;
  end
  initial
  begin
    #100000;
    fail_count++;
    end_sim;
  end
endmodule
